// ---- csi_defines.vh ----
// Purpose: Shared constants of the clock status and interrupt unit.
// Assumes: Eight-bit registers reached over the three-wire serial control port.
// Notes: Offsets, bit positions, masks and reset values are defined here.
`ifndef CSI_DEFINES_VH
`define CSI_DEFINES_VH

// Register offsets on the serial control port.
`define CSI_ADDR_IRQ_EN_LOCK_LOS 7'h68
`define CSI_ADDR_IRQ_EN_REF_HOLD 7'h69
`define CSI_ADDR_LATCHED_LOCK_LOS 7'h6c
`define CSI_ADDR_LIVE_SEL_LOCK_LOS 7'h6d
`define CSI_ADDR_LATCHED_REF_HOLD 7'h6e
`define CSI_ADDR_LIVE_CAL_REF_HOLD 7'h6f

// Bit positions shared by the enable, latched and live registers; cal and select are bits of the live registers only.
`define CSI_BIT_SYNTH 5
`define CSI_BIT_JITTER 4
`define CSI_BIT_INPUT1 1
`define CSI_BIT_INPUT0 0
`define CSI_BIT_REF 1
`define CSI_BIT_HOLD 0
`define CSI_BIT_CAL 2
`define CSI_SEL_HI 7
`define CSI_SEL_LO 6

// Implemented bits of each enable and latched register; all other bits of those read as zero.
`define CSI_MASK_LOCK_LOS 8'h33
`define CSI_MASK_REF_HOLD 8'h03

// Reset values: enables off, latched flags show no event.
`define CSI_RST_ENABLE 8'h00
`define CSI_RST_LATCHED_LOCK_LOS 8'h33
`define CSI_RST_LATCHED_REF_HOLD 8'h03
`define CSI_RST_READ_DATA 8'h00

// Serial frame: one direction bit, seven address bits, eight data bits.
`define CSI_HDR_LAST_BIT 4'h7
`define CSI_FRAME_LAST_BIT 4'hf
`define CSI_BITCNT_RST 4'h0

`endif

// ---- csi_pin_sync.v ----
// Purpose: Three-stage synchroniser with agreement filter for inputs from other domains.
// Assumes: Each bit is independent; multi-bit codes may settle a cycle apart.
// Notes: The output only moves once stages two and three agree on a bit.
`timescale 1ns/1ps
`default_nettype none

module csi_pin_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
  input wire clk_sys,
  input wire rst,
  input wire clkEn,
  input wire [WIDTH-1:0] asyncIn,
  output reg [WIDTH-1:0] syncOut
);

  reg [WIDTH-1:0] stage1_q;
  reg [WIDTH-1:0] stage2_q;
  reg [WIDTH-1:0] stage3_q;
  wire [WIDTH-1:0] agree;

  // Stage one is read by stage two only, so metastability never reaches logic.
  assign agree = ~(stage2_q ^ stage3_q);

  // Chain and filter; a lone glitch that splits stages two and three is ignored.
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      stage1_q <= INIT;
      stage2_q <= INIT;
      stage3_q <= INIT;
      syncOut <= INIT;
    end else if (clkEn) begin
      stage1_q <= asyncIn;
      stage2_q <= stage1_q;
      stage3_q <= stage2_q;
      syncOut <= (syncOut & ~agree) | (stage3_q & agree);
    end
  end

endmodule

`default_nettype wire

// ---- csi_status_irq.v ----
// Purpose: Status latching and active-low interrupt of a dual-PLL clock conditioner.
// Assumes: Status levels and serial port pins are asynchronous to clk_sys.
// Notes: Serial frames are oversampled, so the serial clock must stay well below clk_sys/8.
`timescale 1ns/1ps
`default_nettype none
`include "csi_defines.vh"

module csi_status_irq (
  input wire clk_sys,
  input wire rst,
  input wire clkEn,
  input wire spiSclk,
  input wire spiCsLow,
  input wire spiSdioIn,
  output reg spiSdioOut,
  output reg spiSdioOe,
  input wire synthUnlockLiveLow,
  input wire jitterPllUnlockLiveLow,
  input wire [1:0] inputLosLive,
  input wire referencePresentLive,
  input wire holdoverLiveLow,
  input wire synthCalibrationActive,
  input wire [1:0] selectedInputCode,
  output reg irqOutLow
);

  wire sclkF;
  wire csLowF;
  wire sdioF;
  wire synthLiveF;
  wire jitterLiveF;
  wire [1:0] losLiveF;
  wire refLiveF;
  wire holdLiveF;
  wire calLiveF;
  wire [1:0] selF;
  reg sclkPrev_q;
  reg [3:0] bitCnt_q;
  reg [7:0] shiftIn_q;
  reg [6:0] addr_q;
  reg isRead_q;
  reg [7:0] readShift_q;
  reg [7:0] enLockLos_q;
  reg [7:0] enRefHold_q;
  reg [7:0] latchLockLos_q;
  reg [7:0] latchRefHold_q;
  reg [7:0] latchLockLos_d;
  reg [7:0] latchRefHold_d;
  wire csActive;
  wire sclkRise;
  wire sclkFall;
  wire wrStrobe;
  wire [7:0] wrData;
  wire [7:0] liveLockLos;
  wire [7:0] liveCalRefHold;
  wire [7:0] eventLockLos;
  wire [7:0] eventRefHold;
  wire irqOutLow_d;

  // Serial port pins, filtered so an edge counts once and only once.
  csi_pin_sync #(
    .WIDTH(3),
    .INIT(3'b010)
  ) uPortSync (
    .clk_sys(clk_sys),
    .rst(rst),
    .clkEn(clkEn),
    .asyncIn({spiSclk, spiCsLow, spiSdioIn}),
    .syncOut({sclkF, csLowF, sdioF})
  );

  // Status levels; live-low inputs start high so reset raises no false event.
  csi_pin_sync #(
    .WIDTH(9),
    .INIT(9'h03f)
  ) uStatusSync (
    .clk_sys(clk_sys),
    .rst(rst),
    .clkEn(clkEn),
    .asyncIn({selectedInputCode, synthCalibrationActive, synthUnlockLiveLow,
      jitterPllUnlockLiveLow, inputLosLive, referencePresentLive, holdoverLiveLow}),
    .syncOut({selF, calLiveF, synthLiveF, jitterLiveF, losLiveF, refLiveF, holdLiveF})
  );

  // Live status images as software reads them.
  assign liveLockLos = {selF, synthLiveF, jitterLiveF, 2'b00, losLiveF};
  assign liveCalRefHold = {5'b00000, calLiveF, refLiveF, holdLiveF};

  // A live bit at 0 is an event; inverting the whole image keeps one bit order.
  assign eventLockLos = ~liveLockLos & `CSI_MASK_LOCK_LOS;
  assign eventRefHold = ~liveCalRefHold & `CSI_MASK_REF_HOLD;

  // Register read mux; unmapped and reserved bits read zero.
  function [7:0] regRead;
    input [6:0] addr;
    input [7:0] enA;
    input [7:0] enB;
    input [7:0] latA;
    input [7:0] latB;
    input [7:0] liveA;
    input [7:0] liveB;
    begin
      case (addr)
        `CSI_ADDR_IRQ_EN_LOCK_LOS: regRead = enA;
        `CSI_ADDR_IRQ_EN_REF_HOLD: regRead = enB;
        `CSI_ADDR_LATCHED_LOCK_LOS: regRead = latA;
        `CSI_ADDR_LIVE_SEL_LOCK_LOS: regRead = liveA;
        `CSI_ADDR_LATCHED_REF_HOLD: regRead = latB;
        `CSI_ADDR_LIVE_CAL_REF_HOLD: regRead = liveB;
        default: regRead = `CSI_RST_READ_DATA;
      endcase
    end
  endfunction

  // Frame decode: the write lands on the last rising edge of a write frame.
  assign csActive = ~csLowF;
  assign sclkRise = csActive & sclkF & ~sclkPrev_q;
  assign sclkFall = csActive & ~sclkF & sclkPrev_q;
  assign wrStrobe = sclkRise & ~isRead_q & (bitCnt_q == `CSI_FRAME_LAST_BIT);
  assign wrData = {shiftIn_q[6:0], sdioF};

  // Serial shifter; reads snapshot the register after the address byte.
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sclkPrev_q <= 1'b0;
      bitCnt_q <= `CSI_BITCNT_RST;
      shiftIn_q <= `CSI_RST_READ_DATA;
      addr_q <= 7'h00;
      isRead_q <= 1'b0;
      readShift_q <= `CSI_RST_READ_DATA;
      spiSdioOut <= 1'b0;
      spiSdioOe <= 1'b0;
    end else if (clkEn) begin
      sclkPrev_q <= sclkF;
      if (!csActive) begin
        bitCnt_q <= `CSI_BITCNT_RST;
        isRead_q <= 1'b0;
        spiSdioOe <= 1'b0;
      end else begin
        if (sclkRise) begin
          shiftIn_q <= wrData;
          bitCnt_q <= bitCnt_q + 4'h1;
          if (bitCnt_q == `CSI_HDR_LAST_BIT) begin
            addr_q <= wrData[6:0];
            isRead_q <= shiftIn_q[7 - 1];
            readShift_q <= regRead(wrData[6:0], enLockLos_q, enRefHold_q,
              latchLockLos_q, latchRefHold_q, liveLockLos, liveCalRefHold);
          end
        end
        // Read data changes on falling edges so the host samples it on rising ones.
        if (sclkFall && isRead_q && bitCnt_q > `CSI_HDR_LAST_BIT) begin
          spiSdioOut <= readShift_q[7];
          readShift_q <= {readShift_q[6:0], 1'b0};
          spiSdioOe <= 1'b1;
        end
      end
    end
  end

  // Latched flags: write 1 restores 1, but a live event in the same cycle wins.
  always @* begin
    latchLockLos_d = latchLockLos_q;
    latchRefHold_d = latchRefHold_q;
    if (wrStrobe && addr_q == `CSI_ADDR_LATCHED_LOCK_LOS) begin
      latchLockLos_d = latchLockLos_q | (wrData & `CSI_MASK_LOCK_LOS);
    end
    if (wrStrobe && addr_q == `CSI_ADDR_LATCHED_REF_HOLD) begin
      latchRefHold_d = latchRefHold_q | (wrData & `CSI_MASK_REF_HOLD);
    end
    latchLockLos_d = latchLockLos_d & ~eventLockLos;
    latchRefHold_d = latchRefHold_d & ~eventRefHold;
  end

  // Enable and latched registers.
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      enLockLos_q <= `CSI_RST_ENABLE;
      enRefHold_q <= `CSI_RST_ENABLE;
      latchLockLos_q <= `CSI_RST_LATCHED_LOCK_LOS;
      latchRefHold_q <= `CSI_RST_LATCHED_REF_HOLD;
    end else if (clkEn) begin
      if (wrStrobe && addr_q == `CSI_ADDR_IRQ_EN_LOCK_LOS) begin
        enLockLos_q <= wrData & `CSI_MASK_LOCK_LOS;
      end
      if (wrStrobe && addr_q == `CSI_ADDR_IRQ_EN_REF_HOLD) begin
        enRefHold_q <= wrData & `CSI_MASK_REF_HOLD;
      end
      latchLockLos_q <= latchLockLos_d;
      latchRefHold_q <= latchRefHold_d;
    end
  end

  // A pending flag is an enabled latched bit at 0; the reference flag only
  // changes away from 1 through a loss, so this also covers its change case.
  assign irqOutLow_d = ~(|(enLockLos_q & ~latchLockLos_q & `CSI_MASK_LOCK_LOS) |
    |(enRefHold_q & ~latchRefHold_q & `CSI_MASK_REF_HOLD));

  // Registered so the pin never glitches while flags and enables change together.
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      irqOutLow <= 1'b1;
    end else if (clkEn) begin
      irqOutLow <= irqOutLow_d;
    end
  end

endmodule

`default_nettype wire

// ---- csi_status_irq_note_end.v ----
`timescale 1ns/1ps

// ---- csi_status_irq_properties.sv ----
// Purpose: Port-level checks of the status and interrupt unit.
// Assumes: Serial clock half period of at least ten system clocks.
// Notes: Helper counters age the chip select and the live status inputs.
`timescale 1ns/1ps
`default_nettype none
module csi_status_irq_properties (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic spiSclk,
  input wire logic spiCsLow,
  input wire logic spiSdioOut,
  input wire logic spiSdioOe,
  input wire logic synthUnlockLiveLow,
  input wire logic jitterPllUnlockLiveLow,
  input wire logic [1:0] inputLosLive,
  input wire logic referencePresentLive,
  input wire logic holdoverLiveLow,
  input wire logic irqOutLow
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  wire logic [5:0] liveNow = {synthUnlockLiveLow, jitterPllUnlockLiveLow, inputLosLive,
    referencePresentLive, holdoverLiveLow};
  logic [7:0] csAge_q;
  logic [7:0] liveAge_q;
  logic [5:0] livePrev_q;
  logic evSeen_q;
  // Ages saturate, so a long idle span never wraps back into a short window.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      csAge_q <= 8'h00;
      liveAge_q <= 8'h00;
      livePrev_q <= 6'h3f;
      evSeen_q <= 1'b0;
    end else begin
      csAge_q <= !spiCsLow ? 8'h00 : csAge_q + {7'h00, csAge_q != 8'hff};
      liveAge_q <= (liveNow != livePrev_q) ? 8'h00 : liveAge_q + {7'h00, liveAge_q != 8'hff};
      livePrev_q <= liveNow;
      evSeen_q <= evSeen_q | (liveNow != 6'h3f);
    end
  end
  // The interrupt moves only for a status event or a register write.
  reset_quiet_a: assert property ($fell(rst) |-> !spiSdioOe ##0 irqOutLow[*3])
    else $error("interrupt or data enable active after reset");
  irq_cause_a: assert property ($fell(irqOutLow) |-> evSeen_q)
    else $error("interrupt fell with no status event");
  irq_release_a: assert property ($rose(irqOutLow) |-> csAge_q < 8'h28)
    else $error("interrupt released outside a register write");
  irq_steady_a: assert property (csAge_q > 8'h28 && liveAge_q > 8'h08 |-> $stable(irqOutLow))
    else $error("interrupt moved with no cause");
  oe_start_a: assert property ($rose(spiSdioOe) |-> !spiCsLow && !spiSclk)
    else $error("data enable rose outside a read");
  oe_hold_a: assert property ($rose(spiSdioOe) |=> spiSdioOe[*8])
    else $error("data enable dropped early");
  oe_release_a: assert property (spiSdioOe |-> csAge_q < 8'h08)
    else $error("data enable held after deselect");
  out_timing_a: assert property ($changed(spiSdioOut) |-> !spiSclk)
    else $error("read data changed while serial clock high");
endmodule
`default_nettype wire

// ---- test_clock_status_interrupt_unit.sv ----
// Purpose: Self-checking bench of the status and interrupt unit.
// Assumes: Serial half period of ten clocks, inputs driven on falling edges.
// Notes: Live sources sit in one vector so a loop can visit all six.
`timescale 1ns/1ps
`default_nettype none
`include "csi_defines.vh"
`define CHK(a, e) begin totalChecks++; if ((a) !== (e)) begin mismatches++; \
  $display("FAIL t=%0t got %h exp %h", $time, (a), (e)); end end
module test_clock_status_interrupt_unit;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic spiSclk = 1'b0;
  logic spiCsLow = 1'b1;
  logic clkEn = 1'b1;
  logic tbSdio = 1'b0;
  logic cal = 1'b0;
  logic [1:0] sel = 2'h0;
  logic [5:0] live = 6'h3f;
  logic [7:0] rdat, idle, bitM;
  logic [6:0] enA, latA;
  logic [31:0] rnd;
  logic [2:0] bitPos [6] = '{3'h5, 3'h4, 3'h0, 3'h1, 3'h1, 3'h0};
  integer seed = 32'h04b7;
  int mismatches = 0;
  int totalChecks = 0;
  wire logic spiSdioOut, spiSdioOe, irqOutLow;
  // The device owns the data pin while its enable is high.
  wire logic sdio = spiSdioOe ? spiSdioOut : tbSdio;
  always #5 clk_sys = ~clk_sys;
  csi_status_irq csi_status_irq_inst (.clk_sys, .rst, .clkEn, .spiSclk, .spiCsLow,
    .spiSdioIn(sdio), .spiSdioOut, .spiSdioOe, .synthUnlockLiveLow(live[0]),
    .jitterPllUnlockLiveLow(live[1]), .inputLosLive(live[3:2]), .referencePresentLive(live[4]),
    .holdoverLiveLow(live[5]), .synthCalibrationActive(cal), .selectedInputCode(sel), .irqOutLow);
  // One frame; bits change with the serial clock low and are sampled as it rises.
  task automatic xfer(input logic rd, input logic [6:0] a, input logic [7:0] wd);
    logic [15:0] f;
    f = {rd, a, wd};
    spiCsLow = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      tbSdio = f[i];
      repeat (10) @(negedge clk_sys);
      spiSclk = 1'b1;
      if (i < 8) rdat[i] = sdio;
      repeat (10) @(negedge clk_sys);
      spiSclk = 1'b0;
    end
    repeat (10) @(negedge clk_sys);
    spiCsLow = 1'b1;
    repeat (10) @(negedge clk_sys);
  endtask
  // The bench holds the data pin high in the data phase, so a silent device reads all ones.
  task automatic rdchk(input logic [6:0] a, input logic [7:0] e);
    xfer(1'b1, a, 8'hff);
    `CHK(rdat, e)
  endtask
  function automatic logic [7:0] live6d(input logic [1:0] s, input logic [5:0] v);
    return {s, v[0], v[1], 2'h0, v[3], v[2]};
  endfunction
  task automatic summarize;
    if (mismatches == 0 && totalChecks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Reset values, random live levels, then every source through its event cycle.
  initial begin
    repeat (20) @(negedge clk_sys);
    rst = 1'b0;
    xfer(1'b0, 7'h10, 8'hff);
    rdchk(`CSI_ADDR_IRQ_EN_LOCK_LOS, 8'h00);
    rdchk(`CSI_ADDR_IRQ_EN_REF_HOLD, 8'h00);
    rdchk(`CSI_ADDR_LATCHED_LOCK_LOS, 8'h33);
    rdchk(`CSI_ADDR_LATCHED_REF_HOLD, 8'h03);
    for (int n = 0; n < 8; n++) begin
      rnd = $random(seed);
      live = rnd[5:0];
      sel = {1'b0, rnd[6]};
      cal = rnd[7];
      rdchk(`CSI_ADDR_LIVE_SEL_LOCK_LOS, live6d(sel, live));
      rdchk(`CSI_ADDR_LIVE_CAL_REF_HOLD, {5'h00, cal, live[4], live[5]});
      xfer(1'b0, `CSI_ADDR_IRQ_EN_LOCK_LOS, rnd[15:8]);
      rdchk(`CSI_ADDR_IRQ_EN_LOCK_LOS, rnd[15:8] & 8'h33);
    end
    live = 6'h3f;
    xfer(1'b0, `CSI_ADDR_IRQ_EN_LOCK_LOS, 8'h00);
    xfer(1'b0, `CSI_ADDR_LATCHED_LOCK_LOS, 8'hff);
    xfer(1'b0, `CSI_ADDR_LATCHED_REF_HOLD, 8'hff);
    for (int k = 0; k < 6; k++) begin
      enA = (k < 4) ? `CSI_ADDR_IRQ_EN_LOCK_LOS : `CSI_ADDR_IRQ_EN_REF_HOLD;
      latA = (k < 4) ? `CSI_ADDR_LATCHED_LOCK_LOS : `CSI_ADDR_LATCHED_REF_HOLD;
      idle = (k < 4) ? 8'h33 : 8'h03;
      bitM = 8'h01 << bitPos[k];
      live[k] = 1'b0;
      repeat (60) @(negedge clk_sys);
      live[k] = 1'b1;
      rdchk(latA, idle & ~bitM);
      `CHK(irqOutLow, 1'b1)
      xfer(1'b0, enA, bitM);
      `CHK(irqOutLow, 1'b0)
      live[k] = 1'b0;
      xfer(1'b0, latA, 8'hff);
      rdchk(latA, idle & ~bitM);
      `CHK(irqOutLow, 1'b0)
      live[k] = 1'b1;
      // Clearing the flag with the enable still on must release the pin.
      xfer(1'b0, latA, 8'hff);
      `CHK(irqOutLow, 1'b1)
      // A fresh event with the enable on pulls the pin; disabling releases it.
      live[k] = 1'b0;
      repeat (60) @(negedge clk_sys);
      live[k] = 1'b1;
      `CHK(irqOutLow, 1'b0)
      xfer(1'b0, enA, 8'h00);
      `CHK(irqOutLow, 1'b1)
      xfer(1'b0, latA, 8'hff);
      rdchk(latA, idle);
    end
    // Frozen by the clock enable, the block misses a short loss and keeps its flag.
    clkEn = 1'b0;
    live[0] = 1'b0;
    repeat (20) @(negedge clk_sys);
    live[0] = 1'b1;
    clkEn = 1'b1;
    rdchk(`CSI_ADDR_LATCHED_LOCK_LOS, 8'h33);
    `CHK(irqOutLow, 1'b1)
    summarize();
  end
  // Cut a hang short; the full sequence needs about a third of this span.
  initial begin
    #1000000;
    mismatches++;
    summarize();
  end
endmodule
bind csi_status_irq csi_status_irq_properties csi_status_irq_properties_inst (.clk_sys, .rst,
  .spiSclk, .spiCsLow, .spiSdioOut, .spiSdioOe, .synthUnlockLiveLow, .jitterPllUnlockLiveLow,
  .inputLosLive, .referencePresentLive, .holdoverLiveLow, .irqOutLow);
`default_nettype wire
